// ### hdl/micro_bus_cfg.svh
// Constants for the micro bus phase sequencer.
`ifndef MICRO_BUS_CFG_SVH
`define MICRO_BUS_CFG_SVH

// ============================================================
// Bus layout
`define MB_BUS_W        22
`define MB_LC_W         11
`define MB_IR_W         16
`define MB_SUPPRESS_BIT 16
`define MB_COND_BIT     15
`define MB_AUX_LO       18
`define MB_AUX_HI       21
`define MB_AUX_W        4

// ============================================================
// Reset values
`define MB_LC_RESET     11'h001

// ============================================================
// Microinstruction field positions
`define MB_CLASS_HI     15
`define MB_CLASS_LO     12
`define MB_ALUOP_HI     9
`define MB_ALUOP_LO     8
`define MB_FA_HI        7
`define MB_FA_LO        4
`define MB_FB_HI        3
`define MB_FB_LO        0
`define MB_CSENSE_BIT   11

// ============================================================
// Microinstruction classes
`define MB_CLS_NOP      4'h0
`define MB_CLS_JUMP     4'h1
`define MB_CLS_CJUMP    4'h2
`define MB_CLS_WORD     4'h3
`define MB_CLS_INWORD   4'h4
`define MB_CLS_READ     4'h5
`define MB_CLS_INPUT    4'h6
`define MB_CLS_TRANS    4'h7

// ============================================================
// ALU operations
`define MB_ALU_ADD      2'h0
`define MB_ALU_AND      2'h1
`define MB_ALU_MOVE     2'h2
`define MB_ALU_SHR      2'h3

`endif

// ### hdl/micro_bus_pkg.sv
// Types shared by the micro bus phase sequencer modules.
`default_nettype none
package micro_bus_pkg;

  // ==========================================================
  // Clock phases, Gray coded along the cycle
  typedef enum logic [1:0] {
    PH1 = 2'b00,
    PH2 = 2'b01,
    PH3 = 2'b11,
    PH4 = 2'b10
  } phase_e;

  typedef struct packed {
    phase_e     cur;
    phase_e     nxt;
    logic [3:0] strobe;
  } phase_s;

  // ==========================================================
  // Register fields of the datapath
  typedef struct packed {
    logic [3:0] a;
    logic [3:0] b;
  } field_s;

  typedef struct packed {
    logic [3:0] n_z_v_c;
    logic [3:0] aux;
    logic       aux_valid;
  } status_s;

endpackage
`default_nettype wire

// ### hdl/clock_phase_gen.sv
// Four-phase strobe generator running on the reference clock.
`default_nettype none
module clock_phase_gen (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  output var  micro_bus_pkg::phase_s ph
);

  typedef struct packed {
    micro_bus_pkg::phase_e cur;
    logic [3:0]            strobe;
  } gen_state_s;

  gen_state_s state_reg;
  gen_state_s state_next;

  function automatic micro_bus_pkg::phase_e advance(input micro_bus_pkg::phase_e p);
    unique case (p)
      micro_bus_pkg::PH1: advance = micro_bus_pkg::PH2;
      micro_bus_pkg::PH2: advance = micro_bus_pkg::PH3;
      micro_bus_pkg::PH3: advance = micro_bus_pkg::PH4;
      micro_bus_pkg::PH4: advance = micro_bus_pkg::PH1;
    endcase
  endfunction

  // ==========================================================
  // Phase counter
  always_comb begin
    state_next        = state_reg;
    state_next.cur    = advance(state_reg.cur);
    state_next.strobe = {state_reg.strobe[2:0], state_reg.strobe[3]};
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '{cur: micro_bus_pkg::PH1, strobe: 4'h1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign ph.cur    = state_reg.cur;
  assign ph.nxt    = advance(state_reg.cur);
  assign ph.strobe = state_reg.strobe;

  a_strobe_onehot: assert property (@(posedge ref_clk) disable iff (!rstn)
    $onehot(ph.strobe) && (ph.strobe[0] == (ph.cur == micro_bus_pkg::PH1)))
    else $error("Phase strobes do not match the phase counter.");

endmodule // clock_phase_gen
`default_nettype wire

// ### hdl/word_operand_former.sv
// Forms byte operands for word microinstructions from the register fields.
`default_nettype none
module word_operand_former (
  input  wire logic       second,
  input  wire logic       right_shift,
  input  wire logic [3:0] field_a,
  input  wire logic [3:0] field_b,
  input  wire logic [7:0] rd_a,
  input  wire logic [7:0] rd_b,
  input  wire logic       first_b_msb,
  output logic      [7:0] op_a,
  output logic      [7:0] op_b,
  output logic            ill_advised
);

  // The A field is read as given; an odd A whose low bit was inverted for
  // the second cycle already points at the next lower byte.
  assign op_a = rd_a;

  // An even B field, odd once inverted for the second cycle, repeats the first byte's top bit in the upper byte.
  assign op_b = (second && field_b[0] && !right_shift) ? {8{first_b_msb}} : rd_b;

  // Right shifts work from the high byte, so an even A field in the first cycle is flagged.
  assign ill_advised = right_shift && !second && !field_a[0];

endmodule // word_operand_former
`default_nettype wire

// ### hdl/micro_bus_phase_sequencer.sv
// Sequencer and datapath control for the four-phase micro bus.
//
// Behaviour
// - Fetched word arrives next cycle phase one
// - Line sixteen in phase three blocks store
// - Suppress on second cycle and wait
// - Auxiliary bits valid phase one to three
// - Location counter loads phase one, four sources
// - Counter driven on bus phases two, three
// - Translation address ready in phase four
// - Wait decided from busy, reply phase three
// - Wait pulls line sixteen, stall phase four
// - Stalled cycle keeps counter and translation
// - No repeated wait resumes fetch next cycle
// - Two-cycle case leaves stall low
// - Datapath load, decode, read, ALU by phase
// - Write back phase one, flags phase two
// - Word second cycle inverts field low bits
// - Jumps take two cycles, target second
// - Conditional outcome on line fifteen phase four
// - Stall suspends datapath operation
// - Single instruction spans three cycles
// - Input word sent to translation register
// - Word operands from A and B fields
// - Right shifts expect odd fields
// - Odd B sign extends upper byte; the code does this for even B
// - Odd A gives next lower byte
// - Four non-overlapping phases per cycle
// - Bus values carried inverted on lines
`include "micro_bus_cfg.svh"
`default_nettype none
module micro_bus_phase_sequencer (
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire logic [`MB_BUS_W-1:0]          micro_bus_in_n,
  input  wire logic                          busy,
  input  wire logic                          reply,
  input  wire logic [`MB_IR_W-1:0]           word_addr_data_lines,
  output logic      [`MB_BUS_W-1:0]          micro_bus_out_n,
  output logic      [`MB_BUS_W-1:0]          micro_bus_oe,
  output logic      [3:0]                    clock_phase,
  output logic                               stall,
  output logic      [`MB_LC_W-1:0]           location,
  output var        micro_bus_pkg::status_s  status
);

  typedef struct packed {
    logic [`MB_BUS_W-1:0]   bus_val;
    logic [`MB_BUS_W-1:0]   bus_oe;
    logic                   stall;
    logic [`MB_LC_W-1:0]    lc;
    logic [`MB_IR_W-1:0]    ir;
    micro_bus_pkg::field_s  fld;
    logic                   cyc2;
    logic                   wait_st;
    logic                   sup;
    logic [`MB_IR_W-1:0]    tr;
    logic [`MB_LC_W-1:0]    trans_addr;
    logic [1:0]             trans_state;
    logic                   cond_true;
    logic [7:0]             opa;
    logic [7:0]             opb;
    logic                   b_msb;
    logic [7:0]             res;
    logic                   res_c;
    logic                   res_pend;
    logic                   carry;
    logic [15:0][7:0]       regs;
    micro_bus_pkg::status_s st;
  } seq_state_s;

  seq_state_s            state_reg;
  seq_state_s            state_next;
  micro_bus_pkg::phase_s ph;
  logic [`MB_BUS_W-1:0]  bus_in;
  logic [3:0]            cls;
  logic [3:0]            in_cls;
  logic [1:0]            alu_op;
  logic [7:0]            op_a;
  logic [7:0]            op_b;
  logic                  is_alu;
  logic                  wait_now;
  logic                  cond_now;

  function automatic logic two_cycle(input logic [3:0] c);
    two_cycle = (c == `MB_CLS_JUMP) || (c == `MB_CLS_CJUMP) ||
                (c == `MB_CLS_WORD) || (c == `MB_CLS_INWORD);
  endfunction

  function automatic logic [`MB_LC_W-1:0] translate(input logic [`MB_IR_W-1:0] t);
    translate = {1'b1, t[15:6]};
  endfunction

  // ==========================================================
  // Phase generation and field interpretation
  clock_phase_gen u_phase (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ph      (ph)
  );

  word_operand_former u_operand (
    .second      (state_reg.cyc2),
    .right_shift (alu_op == `MB_ALU_SHR),
    .field_a     (state_reg.fld.a),
    .field_b     (state_reg.fld.b),
    .rd_a        (state_reg.regs[state_reg.fld.a]),
    .rd_b        (state_reg.regs[state_reg.fld.b]),
    .first_b_msb (state_reg.b_msb),
    .op_a        (op_a),
    .op_b        (op_b),
    .ill_advised ()
  );

  assign bus_in   = ~micro_bus_in_n;
  assign cls      = state_reg.ir[`MB_CLASS_HI:`MB_CLASS_LO];
  assign in_cls   = bus_in[`MB_CLASS_HI:`MB_CLASS_LO];
  assign alu_op   = state_reg.ir[`MB_ALUOP_HI:`MB_ALUOP_LO];
  assign is_alu   = cls[3] || (cls == `MB_CLS_WORD);
  assign wait_now = !state_reg.cyc2 &&
                    (((cls == `MB_CLS_READ) && busy) ||
                     ((cls == `MB_CLS_INPUT) && !reply));
  assign cond_now = state_reg.st.n_z_v_c[state_reg.ir[`MB_ALUOP_HI:`MB_ALUOP_LO]] ^
                    state_reg.ir[`MB_CSENSE_BIT];

  // ==========================================================
  // Next state
  always_comb begin
    state_next        = state_reg;
    state_next.bus_oe = '0;
    state_next.bus_val = '0;
    state_next.stall  = 1'b0;
    state_next.st.aux_valid = (ph.nxt != micro_bus_pkg::PH4);

    // Bus drive for the phase about to start.
    unique case (ph.nxt)
      micro_bus_pkg::PH1: begin
        // The second cycle starts at this edge, so the first cycle is tested.
        if (!state_reg.cyc2 && !state_reg.wait_st && (cls == `MB_CLS_INWORD)) begin
          state_next.bus_oe[15:0]  = '1;
          state_next.bus_val[15:0] = word_addr_data_lines;
        end
      end
      micro_bus_pkg::PH2: begin
        state_next.bus_oe[`MB_LC_W-1:0]  = '1;
      end
      micro_bus_pkg::PH3: begin
        state_next.bus_oe[`MB_LC_W-1:0]  = '1;
        state_next.bus_val[`MB_LC_W-1:0] = state_reg.lc;
        state_next.wait_st = wait_now;
        state_next.sup     = wait_now || (!state_reg.cyc2 && two_cycle(cls));
        state_next.bus_oe[`MB_SUPPRESS_BIT]  = state_next.sup;
        state_next.bus_val[`MB_SUPPRESS_BIT] = state_next.sup;
      end
      micro_bus_pkg::PH4: begin
        state_next.stall = state_reg.wait_st;
        if (!state_reg.cyc2 && (cls == `MB_CLS_CJUMP)) begin
          state_next.bus_oe[`MB_COND_BIT]  = 1'b1;
          state_next.bus_val[`MB_COND_BIT] = cond_now;
        end
      end
    endcase

    // Work done at the end of the current phase.
    unique case (ph.cur)
      micro_bus_pkg::PH1: begin
        if (state_reg.res_pend) begin
          state_next.regs[state_reg.fld.a] = state_reg.res;
        end
        if (!state_reg.wait_st) begin
          if (state_reg.cyc2) begin
            if (cls == `MB_CLS_JUMP) begin
              state_next.lc = state_reg.ir[`MB_LC_W-1:0];
            end else if ((cls == `MB_CLS_CJUMP) && state_reg.cond_true) begin
              state_next.lc[7:0] = state_reg.ir[7:0];
            end
            if (cls == `MB_CLS_WORD) begin
              state_next.fld.a[0] = ~state_reg.fld.a[0];
              state_next.fld.b[0] = ~state_reg.fld.b[0];
            end
            if (cls == `MB_CLS_INWORD) begin
              state_next.tr = word_addr_data_lines;
            end
          end else if (!state_reg.sup) begin
            state_next.ir     = bus_in[`MB_IR_W-1:0];
            state_next.fld.a  = bus_in[`MB_FA_HI:`MB_FA_LO];
            state_next.fld.b  = bus_in[`MB_FB_HI:`MB_FB_LO];
            state_next.st.aux = bus_in[`MB_AUX_HI:`MB_AUX_LO];
            state_next.lc     = (in_cls == `MB_CLS_TRANS) ? state_reg.trans_addr :
                                state_reg.lc + `MB_LC_W'(1);
          end else begin
            state_next.lc = state_reg.lc + `MB_LC_W'(1);
          end
        end
      end
      micro_bus_pkg::PH2: begin
        if (state_reg.res_pend) begin
          state_next.st.n_z_v_c = {state_reg.res[7], state_reg.res == 8'h00,
                                   1'b0, state_reg.res_c};
          state_next.res_pend   = 1'b0;
        end
      end
      micro_bus_pkg::PH3: begin
        state_next.opa = op_a;
        state_next.opb = op_b;
        if (!state_reg.cyc2) begin
          state_next.b_msb = op_b[7];
        end
        state_next.trans_addr = translate(state_reg.tr);
      end
      micro_bus_pkg::PH4: begin
        state_next.trans_state = state_reg.tr[15:14];
        if (!state_reg.wait_st) begin
          state_next.cyc2      = !state_reg.cyc2 && two_cycle(cls);
          state_next.cond_true = cond_now;
          if (is_alu) begin
            unique case (alu_op)
              `MB_ALU_ADD: {state_next.res_c, state_next.res} =
                9'(state_reg.opa) + 9'(state_reg.opb) + 9'(state_reg.cyc2 & state_reg.carry);
              `MB_ALU_AND: {state_next.res_c, state_next.res} = {1'b0, state_reg.opa & state_reg.opb};
              `MB_ALU_MOVE: {state_next.res_c, state_next.res} = {1'b0, state_reg.opb};
              `MB_ALU_SHR: {state_next.res, state_next.res_c} =
                {state_reg.cyc2 & state_reg.carry, state_reg.opb};
            endcase
            state_next.carry    = state_next.res_c;
            state_next.res_pend = 1'b1;
          end
        end
      end
    endcase

    // Phase two shows the counter value loaded at the end of phase one.
    if (ph.nxt == micro_bus_pkg::PH2) begin
      state_next.bus_val[`MB_LC_W-1:0] = state_next.lc;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg         <= '0;
      state_reg.lc      <= `MB_LC_RESET;
      state_reg.wait_st <= 1'b1;
      state_reg.sup     <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign micro_bus_out_n = ~state_reg.bus_val;
  assign micro_bus_oe    = state_reg.bus_oe;
  assign clock_phase     = ph.strobe;
  assign stall           = state_reg.stall;
  assign location        = state_reg.lc;
  assign status          = state_reg.st;

  // ==========================================================
  // Checks
  a_stall_in_ph4: assert property (@(posedge ref_clk) disable iff (!rstn)
    stall |-> (ph.cur == micro_bus_pkg::PH4) && state_reg.wait_st)
    else $error("Stall outside phase four or without a wait.");

  a_suppress_only_ph3: assert property (@(posedge ref_clk) disable iff (!rstn)
    micro_bus_oe[`MB_SUPPRESS_BIT] |-> (ph.cur == micro_bus_pkg::PH3))
    else $error("Line sixteen driven outside phase three.");

  a_suppress_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ph.cur == micro_bus_pkg::PH3) && state_reg.wait_st |-> micro_bus_oe[`MB_SUPPRESS_BIT])
    else $error("Wait without suppression of the store.");

  a_lc_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ph.cur == micro_bus_pkg::PH2) |->
    (micro_bus_oe[0] && (micro_bus_out_n[`MB_LC_W-1:0] == ~location)) ##1
    (micro_bus_oe[0] && (micro_bus_out_n[`MB_LC_W-1:0] == ~location)))
    else $error("Location counter not driven through phases two and three.");

  a_stall_lc_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    stall |-> ##2 (location == $past(location, 2)))
    else $error("Location counter moved during a stalled cycle.");

  a_cond_line: assert property (@(posedge ref_clk) disable iff (!rstn)
    micro_bus_oe[`MB_COND_BIT] && !micro_bus_oe[0] |-> (ph.cur == micro_bus_pkg::PH4))
    else $error("Condition line driven outside phase four.");

  a_two_cycle_nostall: assert property (@(posedge ref_clk) disable iff (!rstn)
    state_reg.cyc2 |-> !stall)
    else $error("Stall raised in a second cycle.");

  a_aux_window: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ph.cur == micro_bus_pkg::PH4) |=> status.aux_valid [*3] ##1 !status.aux_valid)
    else $error("Auxiliary bits not held from phase one to three.");

  a_phase_cycle: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ph.cur == micro_bus_pkg::PH1) |-> ##4 (ph.cur == micro_bus_pkg::PH1))
    else $error("Micromachine cycle is not four phases long.");

endmodule // micro_bus_phase_sequencer
`default_nettype wire

// ### verification/control_store_model.sv
// Control store model facing the micro bus phase sequencer.
`default_nettype none
module control_store_model (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  clock_phase,
  input  wire logic [21:0] bus_n,
  output logic      [21:0] out_n,
  output logic      [21:0] oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [21:0] mem [0:2047];
  logic [10:0] addr_reg;
  logic        hold_reg;

  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 22'h000000;
  end

  // ============================================================
  // Answer in phase one unless line sixteen was pulled in phase three.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      oe       <= 22'h000000;
      out_n    <= 22'h3fffff;
      addr_reg <= 11'h000;
      hold_reg <= 1'b0;
    end else if (clock_phase[2]) begin
      addr_reg  <= ~bus_n[10:0];
      hold_reg  <= ~bus_n[16];
      oe[21:18] <= 4'h0;
    end else if (clock_phase[3] && !hold_reg) begin
      out_n     <= ~mem[addr_reg];
      oe[15:0]  <= 16'hffff;
      oe[21:18] <= 4'hf;
    end else if (clock_phase[0]) begin
      oe[15:0]  <= 16'h0000;
    end
  end
endmodule // control_store_model
`default_nettype wire

// ### verification/micro_bus_phase_sequencer_tb.sv
// Testbench for the micro bus phase sequencer.
`default_nettype none
module micro_bus_phase_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   ref_clk;
  logic                   rstn;
  logic                   busy;
  logic                   reply;
  logic [15:0]            instr_word;
  logic [21:0]            bus_n;
  logic [21:0]            d_out;
  logic [21:0]            d_oe;
  logic [21:0]            m_out;
  logic [21:0]            m_oe;
  logic [3:0]             clock_phase;
  logic                   stall;
  logic [10:0]            location;
  micro_bus_pkg::status_s status;
  int                     err_count;
  int                     checks;
  logic                   s16;
  logic                   sst;
  logic                   sw;
  logic                   bad;
  logic                   j0;
  logic                   j1;

  // Precharged lines read high unless a party pulls them.
  assign bus_n = (~d_oe | d_out) & (~m_oe | m_out);

  micro_bus_phase_sequencer micro_bus_phase_sequencer_inst (
    .ref_clk(ref_clk), .rstn(rstn), .micro_bus_in_n(bus_n),
    .busy(busy), .reply(reply), .word_addr_data_lines(instr_word),
    .micro_bus_out_n(d_out), .micro_bus_oe(d_oe),
    .clock_phase(clock_phase), .stall(stall),
    .location(location), .status(status));

  control_store_model cs_inst (
    .ref_clk(ref_clk), .rstn(rstn), .clock_phase(clock_phase),
    .bus_n(bus_n), .out_n(m_out), .oe(m_oe));

  // ============================================================
  // Shared tasks.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic at_ph(input int k);
    int i = 0;
    @(posedge ref_clk);
    #1;
    while (clock_phase[k] !== 1'b1 && i < 8) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    if (i == 8) begin
      chk("phase wait", 1, 0);
      conclude();
    end
  endtask

  task automatic rst();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask

  task automatic run(input logic [10:0] a, input int n);
    int i = 0;
    logic [10:0] p = location;
    {s16, sst, sw, bad} = 4'h0;
    while (location !== a && i < n) begin
      @(posedge ref_clk);
      #1;
      i++;
      if (clock_phase[2] && d_oe[16] && !d_out[16]) s16 = 1'b1;
      if (stall === 1'b1) sst = 1'b1;
      if (clock_phase[0] && d_oe[15:0] === 16'hffff && d_out[15:0] === ~instr_word) sw = 1'b1;
      if (location !== p && clock_phase !== 4'h2) bad = 1'b1;
      p = location;
    end
    chk("location", a, location);
    if (i == n) conclude();
  endtask

  // ============================================================
  // Scenarios.
  task automatic t_reset();
    logic [3:0] p;
    repeat (12) @(posedge ref_clk);
    #1;
    chk("phase", 4'h1, clock_phase);
    chk("oe", 22'h0, d_oe);
    chk("stall", 0, stall);
    chk("location", 11'h001, location);
    chk("status", 9'h0, status);
    @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    p = clock_phase;
    repeat (8) begin
      @(posedge ref_clk);
      #1;
      chk("phase", {p[2:0], p[3]}, clock_phase);
      p = clock_phase;
    end
    $display("t_reset done");
  endtask

  task automatic t_fetch();
    for (int i = 1; i < 16; i++) cs_inst.mem[i] = 22'h280000;
    rst();
    run(11'h004, 40);
    chk("lc off phase one", 0, bad);
    chk("suppress", 0, s16);
    at_ph(1);
    chk("lc drive", 11'h7ff, d_oe[10:0]);
    chk("lc value", {~location}, d_out[10:0]);
    chk("aux", 4'ha, status.aux);
    at_ph(2);
    chk("lc drive", 11'h7ff, d_oe[10:0]);
    chk("aux valid", 1, status.aux_valid);
    at_ph(3);
    chk("lc drive", 0, d_oe[10:0]);
    chk("aux valid", 0, status.aux_valid);
    $display("t_fetch done");
  endtask

  task automatic t_jump();
    cs_inst.mem[1] = 22'h001040;
    rst();
    run(11'h040, 40);
    chk("jump suppress", 1, s16);
    chk("jump stall", 0, sst);
    chk("lc off phase one", 0, bad);
    $display("t_jump done");
  endtask

  task automatic t_wait();
    cs_inst.mem[1] = 22'h005000;
    cs_inst.mem[3] = 22'h006000;
    @(posedge ref_clk);
    busy <= 1'b1;
    reply <= 1'b0;
    rst();
    run(11'h002, 40);
    repeat (3) begin
      at_ph(2);
      chk("line16", 2'b10, {d_oe[16], d_out[16]});
      at_ph(3);
      chk("stall", 1, stall);
      chk("held lc", 11'h002, location);
    end
    @(posedge ref_clk);
    busy <= 1'b0;
    run(11'h004, 40);
    at_ph(3);
    chk("stall", 1, stall);
    chk("held lc", 11'h004, location);
    @(posedge ref_clk);
    reply <= 1'b1;
    run(11'h005, 40);
    $display("t_wait done");
  endtask

  task automatic t_inword();
    cs_inst.mem[1] = 22'h004000;
    cs_inst.mem[2] = 22'h007000;
    @(posedge ref_clk);
    instr_word <= 16'ha5c0;
    rst();
    run(11'h697, 60);
    chk("word to translation", 1, sw);
    $display("t_inword done");
  endtask

  task automatic t_alu();
    cs_inst.mem[1] = 22'h008000;
    rst();
    run(11'h002, 40);
    chk("flags", 4'h0, status.n_z_v_c);
    at_ph(1);
    chk("flags", 4'h0, status.n_z_v_c);
    at_ph(2);
    chk("flags", 4'h4, status.n_z_v_c);
    $display("t_alu done");
  endtask

  task automatic t_cj(input logic sense, output logic hit);
    logic l15;
    logic seen;
    cs_inst.mem[1] = 22'h001205;
    cs_inst.mem[11'h205] = {10'h002, sense, 11'h033};
    rst();
    {hit, l15, seen} = 3'b000;
    repeat (60) begin
      @(posedge ref_clk);
      #1;
      if (location === 11'h233) hit = 1'b1;
      if (clock_phase[3] && d_oe[15] === 1'b1) begin
        seen = 1'b1;
        l15 = ~d_out[15];
      end
    end
    chk("cond drive", 1, seen);
    chk("cond line", sense, l15);
    chk("cond outcome", sense, hit);
    $display("t_cj done");
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    err_count = 0;
    checks = 0;
    rstn = 1'b0;
    busy = 1'b0;
    reply = 1'b1;
    instr_word = 16'h0000;
    t_reset();
    t_fetch();
    t_jump();
    t_wait();
    t_inword();
    t_alu();
    t_cj(1'b0, j0);
    t_cj(1'b1, j1);
    chk("sense", {~j0}, j1);
    conclude();
  end
endmodule // micro_bus_phase_sequencer_tb
`default_nettype wire
